/* rtl/lptpc_top.sv */
// Purpose: Low-power timer and pulse counter with comparator trigger
// Assumes: CLK_SYS 40 MHz; source clocks and pins are foreign and sampled
// Notes:   Source clocks must be well below CLK_SYS/2 to be seen as ticks
// How it works
// [R1] Two modes: periodic time counter, or pulse counter of a selected input.
// [R2] One 15-bit stage is prescaler in time mode, glitch filter in pulse mode.
// [R3] Counter equal to 16-bit compare sets the flag; counter resets unless free-running.
// [R4] Pulse select: 00 comparator, 01..11 alternate pins one to three.
// [R5] Clock select: internal ref, 1 kHz oscillator, 32 kHz RTC clock, external ref.
// [R6] Counting and compare keep working in any power mode while the clock runs.
// [R7] In deepest leakage stop only a bypassed external clock pin is usable.
// [R8] Internal ref lost in leakage stops; others lost in deepest stop.
// [R9] Software keeps the selected clock enabled in the needed low-power modes.
// [R10] Trigger active only while enabled; first stage rises with the flag.
// [R11] Capture stage follows half a prescaler output or source clock period.
// [R12] Selected pulse input is synchronised before filtering and counting.
//
// The strobed register port and the register addresses are this design's own decisions.
`include "lptpc_regs.svh"
module lptpc_top
    import lptpc_pkg::*;
(
    // Clock and reset
    input  wire logic        CLK_SYS,
    input  wire logic        RESET,
    // Register port
    input  wire logic [7:0]  ADDR,
    input  wire logic [31:0] WDATA,
    input  wire logic        WR,
    input  wire logic        RD,
    output logic      [31:0] RDATA,
    // Clock sources, pulse inputs and power state
    input  wire logic        INTERNAL_REFERENCE_CLOCK,
    input  wire logic        LOW_POWER_OSCILLATOR_1KHZ,
    input  wire logic        RTC_32K_CLOCK,
    input  wire logic        EXTERNAL_REFERENCE_CLOCK,
    input  wire logic        ANALOG_COMPARATOR_OUT,
    input  wire logic        ALT_PULSE_PIN_1,
    input  wire logic        ALT_PULSE_PIN_2,
    input  wire logic        ALT_PULSE_PIN_3,
    input  wire logic        OSC_BYPASS,
    input  wire logic [1:0]  POWER_MODE,
    // Outputs
    output logic             IRQ,
    output logic             TRIG_ENABLE,
    output logic             TRIG_CAPTURE
);
    logic [8:0]  s_lvl;
    logic [8:0]  s_rise;
    logic [8:0]  s_fall;
    logic [5:0]  ctrl_q;
    logic [6:0]  psr_q;
    logic [15:0] cmp_q;
    logic [15:0] cnt_q;
    logic [14:0] presc_q;
    logic [1:0]  stat_q;
    logic [1:0]  mask_q;
    logic        filt_q;
    logic        filt_prev_q;
    logic        lost_prev_q;
    lptpc_trig_e trig_q;
    logic [31:0] rdata_q;
    logic        irq_q;
    logic        trig_en_q;
    logic        trig_cap_q;

    // ------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------
    lptpc_sync #(.W(9)) u_sync (
        .clk      (CLK_SYS),
        .rst      (RESET),
        .async_in ({OSC_BYPASS, EXTERNAL_REFERENCE_CLOCK, RTC_32K_CLOCK,
                    LOW_POWER_OSCILLATOR_1KHZ, INTERNAL_REFERENCE_CLOCK,
                    ALT_PULSE_PIN_3, ALT_PULSE_PIN_2, ALT_PULSE_PIN_1,
                    ANALOG_COMPARATOR_OUT}),
        .lvl      (s_lvl),
        .rise     (s_rise),
        .fall     (s_fall)
    );

    // ------------------------------------------------------------
    // Clock availability per power mode
    // ------------------------------------------------------------
    function automatic logic src_ok(input lptpc_clksel_e s, input lptpc_pwr_e m,
                                    input logic byp);
        logic ok;
        ok = 1'b1;
        case (m)
            PM_LOW_LEAKAGE_STOP, PM_VERY_LOW_LEAKAGE_STOP:
                ok = (s != CS_INTERNAL_REF);                     // [R8]
            PM_DEEPEST_LEAKAGE_STOP:
                ok = (s == CS_EXTERNAL_REF) && byp;              // [R7] [R8]
            default:
                ok = 1'b1;
        endcase
        return ok;
    endfunction

    wire logic          en      = ctrl_q[`LPTPC_CTRL_EN];
    wire logic          pmode   = ctrl_q[`LPTPC_CTRL_MODE];
    wire logic          free    = ctrl_q[`LPTPC_CTRL_FREE];
    wire logic [1:0]    in_sel  = ctrl_q[`LPTPC_CTRL_SEL_HI:`LPTPC_CTRL_SEL_LO];
    wire lptpc_clksel_e clk_sel = lptpc_clksel_e'(psr_q[`LPTPC_PSR_CLK_HI:`LPTPC_PSR_CLK_LO]);
    wire logic          byp     = psr_q[`LPTPC_PSR_BYP];
    wire logic [3:0]    pr_raw  = psr_q[`LPTPC_PSR_PR_HI:`LPTPC_PSR_PR_LO];
    wire lptpc_pwr_e    pwr     = lptpc_pwr_e'(POWER_MODE);
    wire logic          avail   = src_ok(clk_sel, pwr, s_lvl[8]);
    // A select value of 15 would need a 16th stage; it is held at the top stage
    wire logic [3:0]    pr      = (pr_raw > `LPTPC_PR_MAX) ? `LPTPC_PR_MAX : pr_raw;
    wire logic [14:0]   pmask   = 15'((16'h0002 << pr) - 16'h0001);
    wire logic          src_tick = en && avail && s_rise[4 + 32'(clk_sel)];  // [R5] [R6]
    wire logic          src_fall = en && avail && s_fall[4 + 32'(clk_sel)];
    wire logic          pulse_raw = s_lvl[in_sel];                           // [R4] [R12]
    wire logic          presc_out = src_tick && ((presc_q & pmask) == pmask);
    wire logic          filt_edge = filt_q && !filt_prev_q;
    wire logic          cnt_tick = en && (pmode ? filt_edge                // [R1]
                                                : (byp ? src_tick : presc_out));
    wire logic          match   = cnt_tick && (cnt_q == cmp_q);
    wire logic          lost    = en && !avail;
    wire logic [1:0]    ev      = {lost && !lost_prev_q, match};
    wire logic          wr_stat = WR && (ADDR == `LPTPC_OFS_STAT);

    // ------------------------------------------------------------
    // Configuration registers
    // ------------------------------------------------------------
    always_ff @(posedge CLK_SYS or posedge RESET) begin
        if (RESET) begin
            ctrl_q <= `LPTPC_CTRL_RST;
            psr_q  <= `LPTPC_PSR_RST;
            cmp_q  <= `LPTPC_CMP_RST;
            mask_q <= `LPTPC_EV_RST;
        end else if (WR) begin
            if (ADDR == `LPTPC_OFS_CTRL) begin
                ctrl_q <= WDATA[5:0];
            end else if (ADDR == `LPTPC_OFS_PRESC) begin
                psr_q <= WDATA[6:0];
            end else if (ADDR == `LPTPC_OFS_CMP) begin
                cmp_q <= WDATA[15:0];
            end else if (ADDR == `LPTPC_OFS_MASK) begin
                mask_q <= WDATA[1:0];
            end
        end
    end

    // ------------------------------------------------------------
    // Shared prescaler / glitch filter stage
    // ------------------------------------------------------------
    always_ff @(posedge CLK_SYS or posedge RESET) begin
        if (RESET) begin
            presc_q <= '0;
        end else if (!en) begin
            presc_q <= '0;
        end else if (!pmode) begin
            if (src_tick) begin
                presc_q <= ((presc_q & pmask) == pmask) ? 15'h0000 : presc_q + 15'h0001;  // [R2]
            end
        end else if (pulse_raw == filt_q) begin
            presc_q <= '0;
        end else if (src_tick) begin
            presc_q <= presc_q + 15'h0001;                                 // [R2]
        end
    end

    // Filtered pulse level; bypass passes the synchronised level straight on
    always_ff @(posedge CLK_SYS or posedge RESET) begin
        if (RESET) begin
            filt_q      <= 1'b0;
            filt_prev_q <= 1'b0;
        end else begin
            filt_prev_q <= filt_q;
            if (!en || !pmode) begin
                filt_q <= pulse_raw;
            end else if (byp) begin
                filt_q <= pulse_raw;                                       // [R12]
            end else if (src_tick && pulse_raw != filt_q && (presc_q & pmask) == pmask) begin
                filt_q <= pulse_raw;                                       // [R2]
            end
        end
    end

    // ------------------------------------------------------------
    // Counter
    // ------------------------------------------------------------
    always_ff @(posedge CLK_SYS or posedge RESET) begin
        if (RESET) begin
            cnt_q <= '0;
        end else if (!en) begin
            cnt_q <= '0;
        end else if (match && !free) begin
            cnt_q <= '0;                                                   // [R3]
        end else if (cnt_tick) begin
            cnt_q <= cnt_q + 16'h0001;                                     // [R1] [R6]
        end
    end

    // ------------------------------------------------------------
    // Status, mask and interrupt
    // ------------------------------------------------------------
    always_ff @(posedge CLK_SYS or posedge RESET) begin
        if (RESET) begin
            stat_q      <= `LPTPC_EV_RST;
            lost_prev_q <= 1'b0;
            irq_q       <= 1'b0;
        end else begin
            lost_prev_q <= lost;
            // A new event in the clearing cycle survives the write-one-to-clear
            stat_q <= (stat_q & ~(wr_stat ? WDATA[1:0] : 2'h0)) | ev;     // [R3]
            irq_q  <= |(((stat_q & ~(wr_stat ? WDATA[1:0] : 2'h0)) | ev) & mask_q);
        end
    end

    // ------------------------------------------------------------
    // Two-stage comparator trigger
    // ------------------------------------------------------------
    always_ff @(posedge CLK_SYS or posedge RESET) begin
        if (RESET) begin
            trig_q     <= TS_IDLE;
            trig_en_q  <= 1'b0;
            trig_cap_q <= 1'b0;
        end else if (!en) begin
            trig_q     <= TS_IDLE;                                         // [R10]
            trig_en_q  <= 1'b0;
            trig_cap_q <= 1'b0;
        end else begin
            trig_cap_q <= 1'b0;
            case (trig_q)
                TS_IDLE: begin
                    if (match) begin
                        trig_q    <= TS_WAIT_HALF;
                        trig_en_q <= 1'b1;                                 // [R10]
                    end
                end
                TS_WAIT_HALF: begin
                    // Bypass and pulse mode wait half a source period, else half a prescaler output
                    if ((byp || pmode) ? src_fall
                                       : (src_tick && (presc_q & pmask) == (pmask >> 1))) begin
                        trig_q     <= TS_IDLE;                             // [R11]
                        trig_en_q  <= 1'b0;
                        trig_cap_q <= 1'b1;
                    end
                end
                default: trig_q <= TS_IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Read port
    // ------------------------------------------------------------
    always_ff @(posedge CLK_SYS or posedge RESET) begin
        if (RESET) begin
            rdata_q <= '0;
        end else if (RD) begin
            if (ADDR == `LPTPC_OFS_CTRL) begin
                rdata_q <= {24'h0000_00, stat_q[0], 1'b0, ctrl_q};
            end else if (ADDR == `LPTPC_OFS_PRESC) begin
                rdata_q <= {25'h000_0000, psr_q};
            end else if (ADDR == `LPTPC_OFS_CMP) begin
                rdata_q <= {16'h0000, cmp_q};
            end else if (ADDR == `LPTPC_OFS_CNT) begin
                rdata_q <= {16'h0000, cnt_q};
            end else if (ADDR == `LPTPC_OFS_STAT) begin
                rdata_q <= {29'h0000_0000, avail, stat_q};
            end else if (ADDR == `LPTPC_OFS_MASK) begin
                rdata_q <= {30'h0000_0000, mask_q};
            end else begin
                rdata_q <= '0;
            end
        end else begin
            rdata_q <= '0;
        end
    end

    assign RDATA        = rdata_q;
    assign IRQ          = irq_q;
    assign TRIG_ENABLE  = trig_en_q;
    assign TRIG_CAPTURE = trig_cap_q;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (RESET);

    sequence s_first_stage;
        match && trig_q == TS_IDLE;
    endsequence

    sequence s_half_wait;
        trig_en_q [*1];
    endsequence

    a_match_sets_flag: assert property (match |=> stat_q[0])                     // [R3]
        else $error("compare match did not set flag");

    a_match_reload: assert property (match && !free && en |=> cnt_q == 16'h0000) // [R3]
        else $error("counter not reset on match");

    a_time_hold: assert property (en && !pmode && !cnt_tick && !match |=> cnt_q == $past(cnt_q)) // [R1]
        else $error("time counter moved without a tick");

    a_count_step: assert property (cnt_tick && !match |=> cnt_q == $past(cnt_q) + 16'h0001) // [R1]
        else $error("counter step wrong");

    a_first_with_flag: assert property (s_first_stage |=> trig_en_q && stat_q[0]) // [R10]
        else $error("first trigger stage not with flag");

    a_trig_needs_en: assert property (!en |=> !trig_en_q && !trig_cap_q)          // [R10]
        else $error("trigger active while disabled");

    a_capture_order: assert property (trig_cap_q |-> $past(trig_en_q) && !trig_en_q) // [R11]
        else $error("capture without first stage");

    a_byp_half: assert property (s_half_wait ##0 (byp && src_fall && trig_q == TS_WAIT_HALF)
                                 |=> trig_cap_q)                                  // [R11]
        else $error("capture not on source falling edge");

    a_deep_clock: assert property (pwr == PM_DEEPEST_LEAKAGE_STOP && !(clk_sel == CS_EXTERNAL_REF && s_lvl[8])
                                   |-> !src_tick)                                 // [R7]
        else $error("unusable clock ticked in deepest stop");

    a_leak_iref: assert property (pwr != PM_RUN && clk_sel == CS_INTERNAL_REF |-> !src_tick) // [R8]
        else $error("internal reference ticked in stop");

    a_filter_hold: assert property (en && pmode && !byp && !src_tick |=> filt_q == $past(filt_q)) // [R2]
        else $error("filter changed without a source tick");

    a_irq_level: assert property (irq_q |-> |(($past(stat_q) | $past(ev)) & $past(mask_q))) // [R3]
        else $error("interrupt without cause");

endmodule // lptpc_top

/* include/lptpc_regs.svh */
// Purpose: Register map, field positions and reset values of the low-power timer
// Assumes: Plain register port, 32-bit data, byte addresses
// Notes:   Definitions only
`ifndef LPTPC_REGS_SVH
`define LPTPC_REGS_SVH

// ------------------------------------------------------------
// Offsets
// ------------------------------------------------------------
`define LPTPC_OFS_CTRL    8'h00
`define LPTPC_OFS_PRESC   8'h04
`define LPTPC_OFS_CMP     8'h08
`define LPTPC_OFS_CNT     8'h0C
`define LPTPC_OFS_STAT    8'h10
`define LPTPC_OFS_MASK    8'h14

// ------------------------------------------------------------
// Fields
// ------------------------------------------------------------
`define LPTPC_CTRL_EN     0
`define LPTPC_CTRL_MODE   1
`define LPTPC_CTRL_FREE   2
`define LPTPC_CTRL_SEL_LO 4
`define LPTPC_CTRL_SEL_HI 5
`define LPTPC_PSR_CLK_LO  0
`define LPTPC_PSR_CLK_HI  1
`define LPTPC_PSR_BYP     2
`define LPTPC_PSR_PR_LO   3
`define LPTPC_PSR_PR_HI   6
`define LPTPC_EV_MATCH    0
`define LPTPC_EV_CLKLOST  1

// ------------------------------------------------------------
// Reset values
// ------------------------------------------------------------
`define LPTPC_CTRL_RST    6'h00
`define LPTPC_PSR_RST     7'h00
`define LPTPC_CMP_RST     16'h0000
`define LPTPC_EV_RST      2'h0
`define LPTPC_PR_MAX      4'hE

`endif

/* include/lptpc_pkg.sv */
// Purpose: Types shared by the low-power timer files
// Assumes: Nothing beyond the register header
// Notes:   Enums carry no explicit codes
package lptpc_pkg;

    typedef enum logic [1:0] {
        PM_RUN,
        PM_LOW_LEAKAGE_STOP,
        PM_VERY_LOW_LEAKAGE_STOP,
        PM_DEEPEST_LEAKAGE_STOP
    } lptpc_pwr_e;

    typedef enum logic [1:0] {
        CS_INTERNAL_REF,
        CS_OSC_1KHZ,
        CS_RTC_32K,
        CS_EXTERNAL_REF
    } lptpc_clksel_e;

    typedef enum logic [1:0] {
        TS_IDLE,
        TS_WAIT_HALF
    } lptpc_trig_e;

endpackage

/* rtl/lptpc_sync.sv */
// Purpose: Two-stage synchroniser with edge detect for a group of foreign signals
// Assumes: Inputs asynchronous to clk
// Notes:   Edges come from the second and third stage only
module lptpc_sync
    import lptpc_pkg::*;
#(
    parameter int W = 9
) (
    // Clock and reset
    input  wire logic         clk,
    input  wire logic         rst,
    // Foreign inputs
    input  wire logic [W-1:0] async_in,
    // Synchronised view
    output logic      [W-1:0] lvl,
    output logic      [W-1:0] rise,
    output logic      [W-1:0] fall
);
    logic [W-1:0] s1_q;
    logic [W-1:0] s2_q;
    logic [W-1:0] s3_q;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s1_q <= '0;
            s2_q <= '0;
            s3_q <= '0;
        end else begin
            s1_q <= async_in;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    genvar g;
    generate
        for (g = 0; g < W; g++) begin : g_edge
            assign lvl[g]  = s2_q[g];
            assign rise[g] = s2_q[g] & ~s3_q[g];
            assign fall[g] = ~s2_q[g] & s3_q[g];
        end
    endgenerate

endmodule // lptpc_sync

/* bench/lptpc_far_model.sv */
// Purpose: Far-side model: source clocks and pulse inputs of the low-power timer
// Assumes: Driven from the bench through tasks, changes right after CLK_SYS edges
// Notes:   Clocks stand low between bursts; pins idle low
module lptpc_far_model (
    // Clock
    input  wire logic       clk,
    // Source clocks: internal ref, 1 kHz, 32 kHz, external ref
    output logic      [3:0] src_clk,
    // Pulse inputs: comparator, alternate pins one to three
    output logic      [3:0] pulse_in
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        src_clk = '0;
        pulse_in = '0;
    end

    // ------------------------------------------------------------
    // Source clock bursts
    // ------------------------------------------------------------
    // Half period of 8 system cycles keeps the source well under CLK_SYS/4
    task automatic src_ticks(input int i, input int n);
        for (int k = 0; k < n; k++) begin
            @(posedge clk);
            src_clk[i] <= 1'b1;
            repeat (8) @(posedge clk);
            src_clk[i] <= 1'b0;
            repeat (7) @(posedge clk);
        end
    endtask

    // ------------------------------------------------------------
    // Pulse inputs
    // ------------------------------------------------------------
    task automatic pulse(input int j, input int hi, input int lo);
        @(posedge clk);
        pulse_in[j] <= 1'b1;
        repeat (hi) @(posedge clk);
        pulse_in[j] <= 1'b0;
        repeat (lo) @(posedge clk);
    endtask
endmodule // lptpc_far_model

/* bench/lptpc_top_tb.sv */
// Purpose: Self-checking bench of the low-power timer through its register port
// Assumes: 40 MHz CLK_SYS, far-side model supplies clocks and pulses
// Notes:   Counts are read back after the sync latency has settled
`include "lptpc_regs.svh"
module lptpc_top_tb;
    import lptpc_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;

    logic        clk_sys = 1'b0;
    logic        reset = 1'b1;
    logic [7:0]  addr = 8'h00;
    logic [31:0] wdata = 32'h0000_0000;
    logic        wr = 1'b0;
    logic        rd = 1'b0;
    logic [31:0] rdata;
    logic        osc_bypass = 1'b0;
    logic [1:0]  power_mode = 2'h0;
    logic        irq;
    logic        trig_enable;
    logic        trig_capture;
    logic [3:0]  src;
    logic [3:0]  pins;
    int          n_mismatch = 0;
    int          n_checks = 0;

    always #12.5 clk_sys = ~clk_sys;

    // ------------------------------------------------------------
    // Instances
    // ------------------------------------------------------------
    lptpc_top u_dut (
        .CLK_SYS(clk_sys), .RESET(reset), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata),
        .INTERNAL_REFERENCE_CLOCK(src[0]), .LOW_POWER_OSCILLATOR_1KHZ(src[1]), .RTC_32K_CLOCK(src[2]),
        .EXTERNAL_REFERENCE_CLOCK(src[3]), .ANALOG_COMPARATOR_OUT(pins[0]), .ALT_PULSE_PIN_1(pins[1]),
        .ALT_PULSE_PIN_2(pins[2]), .ALT_PULSE_PIN_3(pins[3]), .OSC_BYPASS(osc_bypass),
        .POWER_MODE(power_mode), .IRQ(irq), .TRIG_ENABLE(trig_enable), .TRIG_CAPTURE(trig_capture));

    lptpc_far_model u_far (.clk(clk_sys), .src_clk(src), .pulse_in(pins));

    // ------------------------------------------------------------
    // Access and check tasks
    // ------------------------------------------------------------
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk_sys);
        wr <= 1'b0;
    endtask

    task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk_sys);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk_sys);
        rd <= 1'b0;
        #1 d = rdata;
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] v;
        rd_reg(a, v);
        chk(v, exp);
    endtask

    function automatic logic [31:0] ctl(input logic mode, input logic free, input logic [1:0] sel);
        return 32'h0000_0001 | (32'(mode) << `LPTPC_CTRL_MODE) | (32'(free) << `LPTPC_CTRL_FREE)
               | (32'(sel) << `LPTPC_CTRL_SEL_LO);
    endfunction

    function automatic logic [31:0] psr(input logic [1:0] cs, input logic byp, input logic [3:0] p);
        return 32'(cs) | (32'(byp) << `LPTPC_PSR_BYP) | (32'(p) << `LPTPC_PSR_PR_LO);
    endfunction

    // Ticks plus enough system cycles for the sync path to drain
    task automatic run_ticks(input int cs, input int n);
        u_far.src_ticks(cs, n);
        repeat (8) @(posedge clk_sys);
    endtask

    task automatic restart(input logic [31:0] p, input logic [31:0] c, input logic [31:0] ct);
        wr_reg(`LPTPC_OFS_CTRL, 32'h0000_0000);
        wr_reg(`LPTPC_OFS_STAT, 32'h0000_0003);
        wr_reg(`LPTPC_OFS_PRESC, p);
        wr_reg(`LPTPC_OFS_CMP, c);
        wr_reg(`LPTPC_OFS_CTRL, ct);
    endtask

    // ------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------
    task automatic test_reset();
        rd_chk(`LPTPC_OFS_CTRL, 32'h0000_0000);
        rd_chk(`LPTPC_OFS_PRESC, 32'h0000_0000);
        rd_chk(`LPTPC_OFS_CMP, 32'h0000_0000);
        rd_chk(`LPTPC_OFS_CNT, 32'h0000_0000);
        rd_chk(`LPTPC_OFS_MASK, 32'h0000_0000);
        wr_reg(8'h18, 32'h0000_FFFF);
        rd_chk(8'h18, 32'h0000_0000);
        $display("test reset done");
    endtask

    task automatic test_time();
        logic [31:0] v;
        restart(psr(1, 1, 0), 32'h0000_0064, ctl(0, 0, 0));
        run_ticks(1, 5);
        rd_chk(`LPTPC_OFS_CNT, 32'h0000_0005);
        restart(psr(1, 1, 0), 32'h0000_0004, ctl(0, 0, 0));
        run_ticks(1, 5);
        rd_chk(`LPTPC_OFS_CNT, 32'h0000_0000);
        rd_reg(`LPTPC_OFS_STAT, v);
        chk(v & 32'h0000_0003, 32'h0000_0001);
        chk({31'h0, irq}, 32'h0000_0000);
        restart(psr(1, 1, 0), 32'h0000_0004, ctl(0, 1, 0));
        run_ticks(1, 5);
        rd_chk(`LPTPC_OFS_CNT, 32'h0000_0005);
        for (int p = 0; p < 3; p++) begin
            restart(psr(1, 0, 4'(p)), 32'h0000_0064, ctl(0, 0, 0));
            run_ticks(1, 8);
            rd_chk(`LPTPC_OFS_CNT, 32'(8 >> (p + 1)));
        end
        $display("test time done");
    endtask

    task automatic test_trigger();
        int w;
        int c;
        wr_reg(`LPTPC_OFS_MASK, 32'h0000_0001);
        restart(psr(1, 1, 0), 32'h0000_0000, ctl(0, 0, 0));
        w = 0;
        c = 0;
        fork
            run_ticks(1, 1);
            begin
                for (w = 0; w < 200 && trig_enable !== 1'b1; w++) @(posedge clk_sys);
                for (c = 0; c < 100 && trig_capture !== 1'b1; c++) @(posedge clk_sys);
                chk({31'h0, trig_enable}, 32'h0000_0000);
            end
        join
        chk(32'(w < 200), 32'h0000_0001);
        chk(32'(c >= 6 && c <= 12), 32'h0000_0001);
        chk({31'h0, irq}, 32'h0000_0001);
        wr_reg(`LPTPC_OFS_STAT, 32'h0000_0001);
        repeat (2) @(posedge clk_sys);
        chk({31'h0, irq}, 32'h0000_0000);
        wr_reg(`LPTPC_OFS_MASK, 32'h0000_0000);
        // Disable while the first stage stands, before the capture is due
        fork
            run_ticks(1, 1);
            begin
                for (w = 0; w < 200 && trig_enable !== 1'b1; w++) @(posedge clk_sys);
                wr_reg(`LPTPC_OFS_CTRL, 32'h0000_0000);
                repeat (2) @(posedge clk_sys);
                chk({30'h0, trig_enable, trig_capture}, 32'h0000_0000);
            end
        join
        chk(32'(w < 200), 32'h0000_0001);
        chk({31'h0, irq}, 32'h0000_0000);
        $display("test trigger done");
    endtask

    // Two wide pulses count; a short glitch and a pulse on another input do not
    task automatic test_pulse();
        for (int s = 0; s < 4; s++) begin
            restart(psr(0, 0, 0), 32'h0000_FFFF, ctl(1, 0, 2'(s)));
            fork
                u_far.src_ticks(0, 40);
                begin
                    u_far.pulse(s, 48, 48);
                    u_far.pulse(s, 3, 48);
                    u_far.pulse((s + 1) % 4, 48, 48);
                    u_far.pulse(s, 48, 48);
                end
            join
            repeat (8) @(posedge clk_sys);
            rd_chk(`LPTPC_OFS_CNT, 32'h0000_0002);
        end
        $display("test pulse done");
    endtask

    task automatic pw_case(input logic [1:0] pm, input int cs, input logic byp, input int n, input logic lost);
        logic [31:0] v;
        @(posedge clk_sys);
        power_mode <= pm;
        osc_bypass <= byp;
        restart(psr(2'(cs), 1, 0), 32'h0000_FFFF, ctl(0, 0, 0));
        run_ticks(cs, 3);
        rd_chk(`LPTPC_OFS_CNT, 32'(n));
        rd_reg(`LPTPC_OFS_STAT, v);
        chk(v & 32'h0000_0006, lost ? 32'h0000_0002 : 32'h0000_0004);
    endtask

    task automatic test_power();
        for (int cs = 0; cs < 4; cs++) pw_case(0, cs, 0, 3, 0);
        pw_case(1, 0, 0, 0, 1);
        pw_case(2, 0, 0, 0, 1);
        pw_case(2, 2, 0, 3, 0);
        pw_case(1, 1, 0, 3, 0);
        pw_case(3, 3, 1, 3, 0);
        pw_case(3, 3, 0, 0, 1);
        pw_case(3, 1, 0, 0, 1);
        @(posedge clk_sys);
        power_mode <= 2'h0;
        osc_bypass <= 1'b0;
        wr_reg(`LPTPC_OFS_CTRL, 32'h0000_0000);
        $display("test power done");
    endtask

    // ------------------------------------------------------------
    // Sequence, watchdog and verdict
    // ------------------------------------------------------------
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    initial begin
        repeat (10) @(posedge clk_sys);
        reset <= 1'b0;
        test_reset();
        test_time();
        test_trigger();
        test_pulse();
        test_power();
        end_of_test();
    end

    // Whole run needs well under 20k cycles; this cuts a hang at 80k
    initial begin
        #2_000_000;
        n_mismatch++;
        end_of_test();
    end
endmodule // lptpc_top_tb
